// [bench/pix_unpack_props.sv]
`timescale 1ns/100ps
`default_nettype none
module pix_unpack_props (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic [1:0]  chan_kind_i,
    input wire logic        chan_bitmap_ok_i,
    input wire logic        desc_start_i,
    input wire logic [5:0]  desc_type_i,
    input wire logic [7:0]  background_color_blend_i,
    input wire logic        out_valid_i,
    input wire logic        out_ready_o,
    input wire logic        pix_valid_o,
    input wire logic [31:0] pix_data_o,
    input wire logic        pix_ready_i,
    input wire logic        wr_valid_o,
    input wire logic [31:0] wr_data_o,
    input wire logic        wr_ready_i,
    input wire logic [5:0]  misc_bits_o,
    input wire logic        unsupported_o
);
    logic adopted_r;
    // Tracks the free-channel latch so that a later descriptor can be seen to be ignored.
    always_ff @(posedge clk_i) begin
        if (srst_i) adopted_r <= 1'b0;
        else if (desc_start_i && chan_kind_i == 2'h2) adopted_r <= 1'b1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    pix_hold_a: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o))
        else $error("pixel dropped or changed while stalled");
    wr_hold_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
        else $error("packed word dropped or changed while stalled");
    wr_answer_a: assert property (out_valid_i && out_ready_o |=> wr_valid_o)
        else $error("accepted outbound pixel gave no packed word");
    wr_refuse_a: assert property (misc_bits_o > 6'h09 |-> !out_ready_o)
        else $error("outbound pixel accepted for a non packed type");
    wr_narrow_a: assert property (wr_valid_o && misc_bits_o < 6'h05 |-> wr_data_o[31:16] == 16'h0)
        else $error("16-bit packed word has upper bits set");
    type_load_a: assert property (desc_start_i && chan_kind_i != 2'h2 |=> misc_bits_o == $past(desc_type_i))
        else $error("descriptor type not loaded");
    free_take_a: assert property (desc_start_i && chan_kind_i == 2'h2 && !adopted_r |=> misc_bits_o == $past(desc_type_i))
        else $error("free channel did not adopt first type");
    free_keep_a: assert property (desc_start_i && chan_kind_i == 2'h2 && adopted_r |=> $stable(misc_bits_o))
        else $error("free channel type changed after adoption");
    unsup_idle_a: assert property (unsupported_o ##1 unsupported_o |-> !pix_valid_o)
        else $error("pixel delivered for unsupported type");
    bmp_gate_a: assert property (chan_kind_i == 2'h0 && misc_bits_o[5] && !chan_bitmap_ok_i |-> unsupported_o)
        else $error("bitmap type accepted on a channel without table");
    bg_alpha_a: assert property (pix_valid_o && chan_kind_i == 2'h0 && misc_bits_o == 6'h06 |-> pix_data_o[7:0] == background_color_blend_i)
        else $error("24-bit pixel alpha is not the background blend");
    bit_alpha_a: assert property (pix_valid_o && chan_kind_i == 2'h0 && misc_bits_o == 6'h01 |-> pix_data_o[7:0] inside {8'h00, 8'hff})
        else $error("one bit alpha not expanded to 00 or ff");
endmodule : pix_unpack_props
bind rgb_pixel_format_unpacker pix_unpack_props checker_i (.*);
`default_nettype wire

// [bench/pixel_client_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pixel_client_model (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic [1:0] mode_i,
    output logic            ready_o
);
    logic [7:0] lfsr_r;
    // Mode 0 stalls, 1 takes every cycle, 2 takes on an irregular pattern to expose hold bugs.
    always_ff @(posedge clk_i) begin
        if (srst_i) lfsr_r <= 8'h5a;
        else lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) ready_o <= 1'b0;
        else ready_o <= (mode_i == 2'h1) || (mode_i == 2'h2 && lfsr_r[0]);
    end
endmodule : pixel_client_model
`default_nettype wire

// [bench/rgb_pixel_format_unpacker_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module rgb_pixel_format_unpacker_tb;
    logic        clk_i = 1'b0, srst_i = 1'b1, desc_start_i = 1'b0, chan_bitmap_ok_i = 1'b1;
    logic        lut_wr_i = 1'b0, mem_valid_i = 1'b0, out_valid_i = 1'b0, wr_ready_i = 1'b0;
    logic        pix_ready_i, mem_ready_o, pix_valid_o, out_ready_o, wr_valid_o, unsupported_o;
    logic [1:0]  chan_kind_i = 2'h0, mode = 2'h1;
    logic [5:0]  desc_type_i = 6'h00, misc_bits_o;
    logic [7:0]  background_color_blend_i = 8'h9c, lut_addr_i = 8'h00;
    logic [31:0] lut_data_i = 32'h0, mem_data_i = 32'h0, pix_data_o, wr_data_o;
    logic [23:0] out_rgb_i = 24'h0;
    logic [31:0] lut [256];
    logic [31:0] pq[$], wq[$];
    logic [2:0]  hi1 [8] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h5, 3'h6, 3'h7};
    int          seed = 32'h238be518, n_mismatch = 0, check_count = 0;
    rgb_pixel_format_unpacker uut (.*);
    pixel_client_model client (.clk_i(clk_i), .srst_i(srst_i), .mode_i(mode), .ready_o(pix_ready_i));
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) wr_ready_i <= 1'($random(seed));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    always @(negedge clk_i) begin
        if (pix_valid_o && pix_ready_i) check("pixel", pq.size() ? pq.pop_front() : 32'hx, pix_data_o);
        if (wr_valid_o && wr_ready_i) check("packed", wq.size() ? wq.pop_front() : 32'hx, wr_data_o);
    end
    function automatic logic [7:0] rp(input logic [7:0] v, input int n);
        rp = v << (8 - n);
        for (int i = 0; i < 8 - n; i++) rp[i] = v[0];
    endfunction : rp
    function automatic logic [31:0] unpack(input logic [5:0] t, input logic [31:0] w);
        logic [7:0] bg;
        bg = background_color_blend_i;
        case (t)
            6'h00: return {rp(w[15:11], 5), rp(w[10:5], 6), rp(w[4:0], 5), bg};
            6'h01: return {rp(w[14:10], 5), rp(w[9:5], 5), rp(w[4:0], 5), {8{w[15]}}};
            6'h02: return {rp(w[11:8], 4), rp(w[7:4], 4), rp(w[3:0], 4), rp(w[15:12], 4)};
            6'h03: return {rp(w[15:11], 5), rp(w[10:6], 5), rp(w[5:1], 5), {8{w[0]}}};
            6'h04: return {rp(w[15:12], 4), rp(w[11:8], 4), rp(w[7:4], 4), rp(w[3:0], 4)};
            6'h05, 6'h08: return {rp(w[23:18], 6), rp(w[17:12], 6), rp(w[11:6], 6), rp(w[5:0], 6)};
            6'h06: return {w[23:0], bg};
            6'h07: return {w[23:0], w[31:24]};
            6'h09: return w;
            6'h20: return lut[w[7:0]];
            6'h22: return lut[{4'h0, w[3:0]}];
            6'h23: return lut[{4'h8, w[3:0]}];
            6'h24, 6'h25, 6'h26, 6'h27: return lut[{t[1:0], 4'h0, w[1:0]}];
            default: return lut[{hi1[t[2:0]], 4'h0, w[0]}];
        endcase
    endfunction : unpack
    function automatic logic [31:0] pack(input logic [5:0] t, input logic [23:0] c);
        logic [7:0] r, g, b, a;
        {r, g, b} = c;
        a = background_color_blend_i;
        case (t)
            6'h00: return {16'h0, r[7:3], g[7:2], b[7:3]};
            6'h01: return {16'h0, a[7], r[7:3], g[7:3], b[7:3]};
            6'h02: return {16'h0, a[7:4], r[7:4], g[7:4], b[7:4]};
            6'h03: return {16'h0, r[7:3], g[7:3], b[7:3], a[7]};
            6'h04: return {16'h0, r[7:4], g[7:4], b[7:4], a[7:4]};
            6'h05, 6'h08: return {8'h0, r[7:2], g[7:2], b[7:2], a[7:2]};
            6'h06: return {8'h0, c};
            6'h07: return {a, c};
            default: return {c, a};
        endcase
    endfunction : pack
    task automatic do_reset();
        srst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset
    task automatic set_type(input logic [1:0] k, input logic [5:0] t, input logic [5:0] exp);
        chan_kind_i <= k;
        desc_type_i <= t;
        desc_start_i <= 1'b1;
        @(posedge clk_i);
        desc_start_i <= 1'b0;
        @(negedge clk_i);
        check("type", {26'h0, exp}, {26'h0, misc_bits_o});
        @(posedge clk_i);
    endtask : set_type
    // Holds the request until ready is seen before the edge, so that edge is the handshake.
    task automatic put(input bit o, input logic [31:0] w);
        logic ok;
        int n;
        n = 0;
        out_valid_i <= o;
        mem_valid_i <= !o;
        out_rgb_i <= w[23:0];
        mem_data_i <= w;
        do begin
            @(negedge clk_i);
            ok = o ? out_ready_o : mem_ready_o;
            n++;
            @(posedge clk_i);
        end while (ok !== 1'b1 && n < 200);
        if (n >= 200) n_mismatch++;
    endtask : put
    task automatic idle(input string name);
        mem_valid_i <= 1'b0;
        out_valid_i <= 1'b0;
        for (int n = 0; n < 300 && pq.size() + wq.size() > 0; n++) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        check("left over", 0, pq.size() + wq.size());
        $display("test %s done", name);
    endtask : idle
    task automatic burst(input logic [5:0] t, input int n);
        logic [31:0] w;
        for (int i = 0; i < n; i++) begin
            w = i == 0 ? 32'h0 : i == 1 ? 32'hffffffff : $random(seed);
            pq.push_back(chan_kind_i == 2'h1 ? w : unpack(t, w));
            put(0, w);
        end
    endtask : burst
    initial begin
        logic [23:0] c;
        do_reset();
        check("ready after reset", 1, mem_ready_o);
        for (int t = 0; t < 10; t++) begin
            background_color_blend_i <= 8'($random(seed));
            set_type(2'h0, 6'(t), 6'(t));
            mode <= 2'(1 + t % 2);
            burst(6'(t), 6);
            for (int i = 0; i < 4; i++) begin
                c = $random(seed);
                wq.push_back(pack(6'(t), c));
                put(1, {8'h0, c});
            end
            idle("packed types");
        end
        mode <= 2'h0;
        burst(6'h09, 9);
        mem_valid_i <= 1'b0;
        @(negedge clk_i);
        check("full refusal", 0, mem_ready_o);
        @(posedge clk_i);
        mode <= 2'h2;
        idle("fill and drain");
        for (int a = 0; a < 256; a++) begin
            lut[a] = $random(seed);
            lut_wr_i <= 1'b1;
            lut_addr_i <= 8'(a);
            lut_data_i <= lut[a];
            @(posedge clk_i);
        end
        lut_wr_i <= 1'b0;
        for (int t = 6'h20; t < 6'h30; t++) begin
            if (t != 6'h21) set_type(2'h0, 6'(t), 6'(t));
            if (t != 6'h21) burst(6'(t), 5);
            idle("bitmap types");
        end
        chan_bitmap_ok_i <= 1'b0;
        set_type(2'h0, 6'h20, 6'h20);
        check("no table", 1, unsupported_o);
        put(0, 32'h5);
        idle("no table");
        chan_bitmap_ok_i <= 1'b1;
        set_type(2'h0, 6'h21, 6'h21);
        check("unknown type", 1, unsupported_o);
        put(0, 32'h3);
        idle("unknown type");
        set_type(2'h1, 6'h2d, 6'h2d);
        burst(6'h2d, 6);
        idle("misc channel");
        do_reset();
        set_type(2'h2, 6'h07, 6'h07);
        set_type(2'h2, 6'h00, 6'h07);
        burst(6'h07, 4);
        idle("free channel");
        give_verdict();
    end
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule : rgb_pixel_format_unpacker_tb
`default_nettype wire

// [common/pix_fmt_pkg.sv]
package pix_fmt_pkg;
    localparam int TYPE_W  = 6;
    localparam int WORD_W  = 32;
    localparam int FIFO_DEPTH = 8;
    localparam int LUT_ENTRIES = 256;
    localparam int LUT_AW      = 8;

    localparam logic [5:0] T_RGB565   = 6'h00;
    localparam logic [5:0] T_ARGB1555 = 6'h01;
    localparam logic [5:0] T_ARGB4444 = 6'h02;
    localparam logic [5:0] T_RGBA5551 = 6'h03;
    localparam logic [5:0] T_RGBA4444 = 6'h04;
    localparam logic [5:0] T_ARGB6666 = 6'h05;
    localparam logic [5:0] T_RGB888   = 6'h06;
    localparam logic [5:0] T_ARGB8888 = 6'h07;
    localparam logic [5:0] T_RGBA6666 = 6'h08;
    localparam logic [5:0] T_RGBA8888 = 6'h09;
    localparam logic [5:0] T_BMP8     = 6'h20;
    localparam logic [5:0] T_BMP4_LO  = 6'h22;
    localparam logic [5:0] T_BMP4_HI  = 6'h23;
    localparam logic [5:0] T_BMP2_0   = 6'h24;
    localparam logic [5:0] T_BMP2_3   = 6'h27;
    localparam logic [5:0] T_BMP1_0   = 6'h28;
    localparam logic [5:0] T_BMP1_7   = 6'h2f;

    localparam logic [3:0] BMP4_HI_NIBBLE = 4'h8;
    // Upper three table address bits for the 1-bit bitmap types 28h..2Fh, index = type[2:0].
    localparam logic [23:0] BMP1_HI_BITS = {3'h7, 3'h6, 3'h5, 3'h0, 3'h0, 3'h2, 3'h1, 3'h0};

    typedef enum logic [1:0] {
        CHAN_RGB  = 2'h0,
        CHAN_MISC = 2'h1,
        CHAN_FREE = 2'h2
    } chan_kind_e;

    typedef enum logic {
        ADOPT_WAIT = 1'b0,
        ADOPT_HELD = 1'b1
    } adopt_state_e;
endpackage : pix_fmt_pkg

// [rtl/rgb_pixel_format_unpacker.sv]
`timescale 1ns/100ps
`default_nettype none

// Valid/ready FIFO that decouples the fetch side from the pixel decoder.
// The head word is read straight from storage, so a word pushed at one edge
// is offered to the reader in the next cycle, with no extra latency.
// Occupancy is counted one bit wider than the pointers, which keeps a full
// FIFO apart from an empty one without a spare slot.
module pixel_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // Storage has no reset: only the pointers and the count decide what is
    // valid, and leaving the data out of reset keeps it plain flip-flops
    // without a reset tree.

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // A push into a full FIFO is refused even when a pop falls in the same
    // cycle; that costs one bubble at full but keeps ready off the pop path.
    assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage is written only on an accepted push.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // Pointer wrap relies on DEPTH being a power of two.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push && !pop) count_r <= count_r + 1'b1;
            else if (pop && !push) count_r <= count_r - 1'b1;
        end
    end
endmodule : pixel_fifo

// Format converter between memory pixel words and the client stream, in both directions:
// 32-bit RGBA to the client, 24-bit RGB from it, under control of the descriptor type code.

// Functional notes
// - Every RGB type reaches the client as 32-bit RGBA, 8 bits per component.
// - Short components fill missing low bits by copying their lowest supplied bit.
// - Outbound 24-bit RGB gets alpha from background_color_blend to form ARGB.
// - Outbound formats with short components drop the least significant bits.
// - Type 0: blue 4:0, green 10:5, red 15:11, no stored alpha.
// - Type 1: blue 4:0, green 9:5, red 14:10, bit 15 gives alpha 00/ff.
// - Type 2: blue 3:0, green 7:4, red 11:8, alpha 15:12.
// - Type 3: alpha bit 0 gives 00/ff, blue 5:1, green 10:6, red 15:11.
// - Type 4: alpha 3:0, blue 7:4, green 11:8, red 15:12.
// - Types 5 and 8: alpha 5:0, blue 11:6, green 17:12, red 23:18.
// - Type 6: blue 7:0, green 15:8, red 23:16, alpha from background blend.
// - Type 7: blue 7:0, green 15:8, red 23:16, alpha 31:24.
// - Type 9: alpha 7:0, blue 15:8, green 23:16, red 31:24.
// - Table lookup only on bitmap-capable channels; table gives the 32-bit RGBA pixel.
// - Type 20h: 8-bit pixel addresses the 256x32 table directly.
// - Types 22h/23h: 4-bit pixel is low nibble; high nibble 0 or 1000.
// - Types 24h-27h: 2-bit pixel, bits 5:2 zero, bits 7:6 from type.
// - Types 28h-2Fh: 1-bit pixel, bits 4:1 zero, bits 7:5 per type table.
// - Miscellaneous channel passes data unchanged, single buffer.
// - Miscellaneous transfer size is the data type field read as bits.
// - Free channel adopts the data type of the first descriptor invoking it.
module rgb_pixel_format_unpacker
    import pix_fmt_pkg::*;
#(
    parameter int FIFO_D = FIFO_DEPTH
) (
    input  wire logic              clk_i,
    input  wire logic              srst_i,

    input  wire logic [1:0]        chan_kind_i,
    input  wire logic              chan_bitmap_ok_i,
    input  wire logic              desc_start_i,
    input  wire logic [TYPE_W-1:0] desc_type_i,
    input  wire logic [7:0]        background_color_blend_i,

    input  wire logic              lut_wr_i,
    input  wire logic [LUT_AW-1:0] lut_addr_i,
    input  wire logic [WORD_W-1:0] lut_data_i,

    input  wire logic              mem_valid_i,
    input  wire logic [WORD_W-1:0] mem_data_i,
    output logic                   mem_ready_o,
    output logic                   pix_valid_o,
    output logic      [WORD_W-1:0] pix_data_o,
    input  wire logic              pix_ready_i,

    input  wire logic              out_valid_i,
    input  wire logic [23:0]       out_rgb_i,
    output logic                   out_ready_o,
    output logic                   wr_valid_o,
    output logic      [WORD_W-1:0] wr_data_o,
    input  wire logic              wr_ready_i,

    output logic      [TYPE_W-1:0] misc_bits_o,
    output logic                   unsupported_o
);
    // Component expansion to eight bits. The missing low bits copy the lowest
    // supplied bit, so full scale stays full scale and zero stays zero, where
    // plain zero padding would leave a white pixel slightly grey.
    function automatic logic [7:0] ex6(input logic [5:0] v);
        return {v, {2{v[0]}}};
    endfunction : ex6

    function automatic logic [7:0] ex5(input logic [4:0] v);
        return {v, {3{v[0]}}};
    endfunction : ex5

    function automatic logic [7:0] ex4(input logic [3:0] v);
        return {v, {4{v[0]}}};
    endfunction : ex4

    // Descriptor type state.
    adopt_state_e       adopt_r;
    logic [TYPE_W-1:0]  type_r;

    // Color table storage.
    logic [WORD_W-1:0]  lut_r [LUT_ENTRIES];

    // Head of the inbound FIFO.
    logic               fifo_valid;
    logic [WORD_W-1:0]  fifo_data;
    logic               fifo_pop;

    // Classification of the current type.
    logic               is_rgb;
    logic               is_bmp;
    logic               is_misc;
    logic               supported;

    // Inbound decode and client output register.
    logic [LUT_AW-1:0]  lut_idx;
    logic [WORD_W-1:0]  rgba_nxt;
    logic               pix_valid_r;
    logic [WORD_W-1:0]  pix_data_r;
    logic               stage_free;

    // Outbound pack and memory output register.
    logic [WORD_W-1:0]  pack_nxt;
    logic               wr_valid_r;
    logic [WORD_W-1:0]  wr_data_r;
    logic               wr_free;

    // Types must change only while both streams are idle: words already queued
    // are decoded with whatever type is current when they leave the FIFO.
    // A free channel latches only the first descriptor's type; others follow every descriptor.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            adopt_r <= ADOPT_WAIT;
            type_r  <= '0;
        end else if (desc_start_i) begin
            if (chan_kind_i != CHAN_FREE) begin
                type_r <= desc_type_i;
            end else if (adopt_r == ADOPT_WAIT) begin
                type_r  <= desc_type_i;
                adopt_r <= ADOPT_HELD;
            end
        end
    end

    // A misc channel never decodes. Bitmap codes count only where the channel
    // has a color table behind it; everything else is refused as unsupported.
    assign is_misc = (chan_kind_i == CHAN_MISC);
    assign is_rgb  = !is_misc && (type_r <= T_RGBA8888);
    assign is_bmp  = !is_misc && chan_bitmap_ok_i &&
                     (type_r == T_BMP8 || (type_r >= T_BMP4_LO && type_r <= T_BMP1_7));
    assign supported     = is_misc || is_rgb || is_bmp;
    assign unsupported_o = !supported;
    assign misc_bits_o   = type_r;

    // Color table write port, one entry per cycle. The table has no reset, so
    // an entry is undefined until it has been written; bitmap frames must
    // not start before every entry that they can address is loaded.
    always_ff @(posedge clk_i) begin
        if (lut_wr_i) begin
            lut_r[lut_addr_i] <= lut_data_i;
        end
    end

    // Single FIFO in front of the decoder; for misc channels it is the one client buffer.
    // Its depth sets how far the fetch side can run ahead of a stalled client.
    pixel_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_D)
    ) u_in_fifo (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (mem_valid_i),
        .in_data_i   (mem_data_i),
        .in_ready_o  (mem_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

    // Table address per bitmap type. The forced upper bits give each small
    // palette a fixed window, but windows overlap (22h, 24h, 28h, 2Bh and 2Ch all hold entry 0),
    // so only layers with disjoint windows can share one table without reloading it between frames.
    always_comb begin
        lut_idx = fifo_data[7:0];
        if (type_r == T_BMP4_LO) begin
            lut_idx = {4'h0, fifo_data[3:0]};
        end else if (type_r == T_BMP4_HI) begin
            lut_idx = {BMP4_HI_NIBBLE, fifo_data[3:0]};
        end else if (type_r >= T_BMP2_0 && type_r <= T_BMP2_3) begin
            lut_idx = {type_r[1:0], 4'h0, fifo_data[1:0]};
        end else if (type_r >= T_BMP1_0) begin
            lut_idx = {BMP1_HI_BITS[3*type_r[2:0] +: 3], 4'h0, fifo_data[0]};
        end
    end

    // Inbound decode. Misc channels pass the word through untouched, bitmap
    // types read the table, and the RGB codes expand each component.
    // Client word layout is red 31:24, green 23:16, blue 15:8, alpha 7:0.
    always_comb begin
        rgba_nxt = fifo_data;
        if (is_bmp) begin
            rgba_nxt = lut_r[lut_idx];
        end else if (is_rgb) begin
            unique case (type_r)
                T_RGB565: rgba_nxt = {ex5(fifo_data[15:11]), ex6(fifo_data[10:5]),
                                      ex5(fifo_data[4:0]), background_color_blend_i};
                T_ARGB1555: rgba_nxt = {ex5(fifo_data[14:10]), ex5(fifo_data[9:5]),
                                        ex5(fifo_data[4:0]), {8{fifo_data[15]}}};
                T_ARGB4444: rgba_nxt = {ex4(fifo_data[11:8]), ex4(fifo_data[7:4]),
                                        ex4(fifo_data[3:0]), ex4(fifo_data[15:12])};
                T_RGBA5551: rgba_nxt = {ex5(fifo_data[15:11]), ex5(fifo_data[10:6]),
                                        ex5(fifo_data[5:1]), {8{fifo_data[0]}}};
                T_RGBA4444: rgba_nxt = {ex4(fifo_data[15:12]), ex4(fifo_data[11:8]),
                                        ex4(fifo_data[7:4]), ex4(fifo_data[3:0])};
                T_ARGB6666, T_RGBA6666: rgba_nxt = {ex6(fifo_data[23:18]),
                    ex6(fifo_data[17:12]), ex6(fifo_data[11:6]), ex6(fifo_data[5:0])};
                T_RGB888: rgba_nxt = {fifo_data[23:0], background_color_blend_i};
                T_ARGB8888: rgba_nxt = {fifo_data[23:0], fifo_data[31:24]};
                T_RGBA8888: rgba_nxt = fifo_data;
                default: rgba_nxt = fifo_data;
            endcase
        end
    end

    // The output register takes a new pixel whenever it is empty or the client
    // takes the current one in the same cycle, so back-to-back words keep one
    // pixel per clock.
    // Unsupported types drain the FIFO so the fetch side never deadlocks on a bad descriptor.
    assign stage_free  = !pix_valid_r || pix_ready_i;
    assign fifo_pop    = supported ? stage_free : 1'b1;
    assign pix_valid_o = pix_valid_r;
    assign pix_data_o  = pix_data_r;

    // A pixel is captured only when the FIFO holds one for a supported type.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pix_valid_r <= 1'b0;
            pix_data_r  <= '0;
        end else if (stage_free) begin
            pix_valid_r <= fifo_valid && supported;
            if (fifo_valid && supported) begin
                pix_data_r <= rgba_nxt;
            end
        end
    end

    // Outbound pack. Components are cut to the width of the chosen layout by
    // keeping their most significant bits; there is no rounding, so a round
    // trip through a short layout loses the low bits for good.
    // Outbound: input RGB sits red 23:16, green 15:8, blue 7:0.
    always_comb begin
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic [7:0] a;

        r = out_rgb_i[23:16];
        g = out_rgb_i[15:8];
        b = out_rgb_i[7:0];
        a = background_color_blend_i;

        pack_nxt = {a, r, g, b};
        unique case (type_r)
            T_RGB565:   pack_nxt = {16'h0000, r[7:3], g[7:2], b[7:3]};
            T_ARGB1555: pack_nxt = {16'h0000, a[7], r[7:3], g[7:3], b[7:3]};
            T_ARGB4444: pack_nxt = {16'h0000, a[7:4], r[7:4], g[7:4], b[7:4]};
            T_RGBA5551: pack_nxt = {16'h0000, r[7:3], g[7:3], b[7:3], a[7]};
            T_RGBA4444: pack_nxt = {16'h0000, r[7:4], g[7:4], b[7:4], a[7:4]};
            T_ARGB6666, T_RGBA6666: pack_nxt = {8'h00, r[7:2], g[7:2], b[7:2], a[7:2]};
            T_RGB888:   pack_nxt = {8'h00, r, g, b};
            T_RGBA8888: pack_nxt = {r, g, b, a};
            default:    pack_nxt = {a, r, g, b};
        endcase
    end

    // The packed word waits in its register until memory takes it, so the
    // client sees back pressure only through out_ready_o.
    // Packing is defined only for the RGB codes; other codes refuse outbound pixels.
    assign wr_free     = !wr_valid_r || wr_ready_i;
    assign out_ready_o = wr_free && is_rgb;
    assign wr_valid_o  = wr_valid_r;
    assign wr_data_o   = wr_data_r;

    // A packed word is captured only for a pixel accepted on an RGB code.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_valid_r <= 1'b0;
            wr_data_r  <= '0;
        end else if (wr_free) begin
            wr_valid_r <= out_valid_i && is_rgb;
            if (out_valid_i && is_rgb) begin
                wr_data_r <= pack_nxt;
            end
        end
    end
endmodule : rgb_pixel_format_unpacker

`default_nettype wire
